/* rtl/mxc_mem_ctrl.sv */
// memory-access control: address mode, wait states, program writes, power and prescale bits
// Notes on behaviour
// RL1: program addresses limited to 0xFFFF narrow, 0x1FFFFF wide.
// RL2: after reset fetch restarts at zero in narrow mode.
// RL3: fetches up to 0x3FFF hit program SRAM, above go to flash/external.
// RL4: core held until boot copy completes after reset or software reboot.
// RL5: program SRAM fetches take one clock regardless of wait setting.
// RL6: program wait field 000 gives one clock, 111 gives eight.
// RL7: software picks wait values by clock rate and shadowing.
// RL8: non-SRAM program access lasts wait field plus one clocks.
// RL9: mode register write honoured only right after 0xAA then 0x55 to timed-access.
// RL10: unlock depends on instruction order only, not on elapsed time.
// RL11: mode register always reads back its contents.
// RL12: mode bit 1 selects wide 24-bit addressing, clear is 16-bit.
// RL13: mode may change at any time during execution.
// RL14: move, jump and stack behaviour follows the active address mode.
// RL15: program write enable sends pointer external writes into program memory.
// RL16: register-indirect program writes use upper, port two, register; narrow forces top byte zero.
// RL17: pointer moves take top byte from the selected pointer's extended byte.
// RL18: power bit 0 enters power management, bit 1 enters stop.
// RL19: with switchback enabled, wake events clear power management bit.
// RL20: power bit 3 drives regulator standby.
// RL21: power bits 7 and 6 double first and second serial rates.
// RL22: data addresses up to 0x7FFF are on-chip, above go external up to 2 MB.
// RL23: data wait field sets data strobe width, 000 one clock, 111 eight.
// RL24: clock bits 3 and 4 pick divide by 4 or 12 for timers 0 and 1.
// RL25: data wait change applies from the next data access.
`timescale 1ns/1ps
`default_nettype none
`include "mxc_map.svh"
module mxc_mem_ctrl (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic other_instr,
  input wire logic software_reboot_bit,
  input wire logic boot_copy_done,
  output logic boot_copy_start,
  output logic core_run,
  output logic fetch_restart,
  input wire logic fetch_req,
  input wire logic [23:0] fetch_addr,
  output logic [23:0] prog_addr,
  output logic prog_sram_sel,
  output logic fetch_busy,
  output logic fetch_done,
  input wire mxc_pkg::mxc_xm_req_t xm_req,
  input wire mxc_pkg::mxc_ptr_regs_t ptr_regs,
  output logic [23:0] xm_addr,
  output logic [7:0] xm_wdata,
  output logic xm_wr,
  output logic xm_to_prog,
  output logic xm_onchip,
  output logic xm_strobe,
  output logic xm_done,
  input wire logic wake_event,
  output logic addr_width_select,
  output logic power_manage_mode,
  output logic stop_mode,
  output logic regulator_standby,
  output logic serial_first_double_rate,
  output logic serial_second_double_rate,
  output logic timer_zero_tick,
  output logic timer_one_tick
);
  import mxc_pkg::*;

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_meta_q;
  logic rst_sync_q;
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ----------------------------------------
  // register file
  // ----------------------------------------
  logic [7:0] power_config_register_q;
  logic [7:0] clock_control_register_q;
  logic [2:0] program_wait_field_q;
  logic [1:0] address_mode_register_q;
  mxc_ta_state_t ta_state_q;

  function automatic logic hit(input logic we, input logic [7:0] a, input logic [7:0] target);
    hit = we && (a == target);
  endfunction

  logic wr_power_config_register;
  logic wr_clock_and_data_wait_control;
  logic wr_wait;
  logic wr_mode;
  logic wr_ta;
  logic mode_unlocked;
  assign wr_power_config_register = hit(sfr_wr, sfr_addr, `MXC_ADDR_POWER_CFG);
  assign wr_clock_and_data_wait_control = hit(sfr_wr, sfr_addr, `MXC_ADDR_CLK_CTRL);
  assign wr_wait = hit(sfr_wr, sfr_addr, `MXC_ADDR_PROG_WAIT);
  assign wr_mode = hit(sfr_wr, sfr_addr, `MXC_ADDR_ADDR_MODE);
  assign wr_ta = hit(sfr_wr, sfr_addr, `MXC_ADDR_TIMED_ACCESS);
  assign mode_unlocked = (ta_state_q == TA_OPEN);

  // the window opens for exactly one instruction; waits do not count as instructions
  always_ff @(posedge ref_clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      ta_state_q <= TA_LOCKED;
    else if (wr_ta && sfr_wdata == `MXC_TA_KEY_FIRST)
      ta_state_q <= TA_GOT_FIRST; // RL9
    else if (wr_ta && sfr_wdata == `MXC_TA_KEY_SECOND && ta_state_q == TA_GOT_FIRST)
      ta_state_q <= TA_OPEN; // RL9
    else if (sfr_wr || other_instr)
      ta_state_q <= TA_LOCKED; // RL10
  end

  // mode register, reset to narrow; reboot also restores narrow
  always_ff @(posedge ref_clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      address_mode_register_q <= `MXC_RST_ADDR_MODE; // RL2
    else if (software_reboot_bit)
      address_mode_register_q <= `MXC_RST_ADDR_MODE; // RL2
    else if (wr_mode && mode_unlocked)
      address_mode_register_q <= sfr_wdata[1:0]; // RL9 RL13
  end

  always_ff @(posedge ref_clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      program_wait_field_q <= `MXC_RST_PROG_WAIT;
    else if (wr_wait)
      program_wait_field_q <= sfr_wdata[2:0]; // RL6
  end

  always_ff @(posedge ref_clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      clock_control_register_q <= `MXC_RST_CLK_CTRL;
    else if (wr_clock_and_data_wait_control)
      clock_control_register_q <= sfr_wdata; // RL23
  end

  // a software write to the power register wins over a same-cycle switchback
  always_ff @(posedge ref_clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      power_config_register_q <= `MXC_RST_POWER_CFG;
    else if (wr_power_config_register)
      power_config_register_q <= sfr_wdata; // RL18
    else if (wake_event && power_config_register_q[`MXC_PC_SWB])
      power_config_register_q[`MXC_PC_PMM] <= 1'b0; // RL19
  end

  // reads take one clock; unmapped offsets answer zero
  always_ff @(posedge ref_clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      sfr_rdata <= 8'h00;
    else if (sfr_rd)
    begin
      if (sfr_addr == `MXC_ADDR_POWER_CFG)
        sfr_rdata <= power_config_register_q;
      else if (sfr_addr == `MXC_ADDR_CLK_CTRL)
        sfr_rdata <= clock_control_register_q;
      else if (sfr_addr == `MXC_ADDR_PROG_WAIT)
        sfr_rdata <= {5'h00, program_wait_field_q};
      else if (sfr_addr == `MXC_ADDR_ADDR_MODE)
        sfr_rdata <= {6'h00, address_mode_register_q}; // RL11
      else
        sfr_rdata <= 8'h00;
    end
  end

  // ----------------------------------------
  // mode and power outputs
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      addr_width_select <= 1'b0;
      power_manage_mode <= 1'b0;
      stop_mode <= 1'b0;
      regulator_standby <= 1'b0;
      serial_first_double_rate <= 1'b0;
      serial_second_double_rate <= 1'b0;
    end
    else
    begin
      addr_width_select <= address_mode_register_q[`MXC_AM_BIT]; // RL12 RL14
      power_manage_mode <= power_config_register_q[`MXC_PC_PMM]; // RL18
      stop_mode <= power_config_register_q[`MXC_PC_STOP]; // RL18
      regulator_standby <= power_config_register_q[`MXC_PC_RSM]; // RL20
      serial_first_double_rate <= power_config_register_q[`MXC_PC_SER1X]; // RL21
      serial_second_double_rate <= power_config_register_q[`MXC_PC_SER2X]; // RL21
    end
  end

  logic wide;
  logic [23:0] space_mask;
  assign wide = address_mode_register_q[`MXC_AM_BIT];
  assign space_mask = wide ? `MXC_WIDE_MASK : `MXC_NARROW_MASK; // RL1

  // ----------------------------------------
  // boot hold
  // ----------------------------------------
  // core stays stopped until the loader has shadowed the low flash into program SRAM
  logic boot_pending_q;
  always_ff @(posedge ref_clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      boot_pending_q <= 1'b1;
      boot_copy_start <= 1'b1;
      core_run <= 1'b0;
      fetch_restart <= 1'b0;
    end
    else
    begin
      boot_copy_start <= software_reboot_bit;
      fetch_restart <= 1'b0;
      if (software_reboot_bit)
      begin
        boot_pending_q <= 1'b1; // RL4
        core_run <= 1'b0;
      end
      else if (boot_pending_q && boot_copy_done)
      begin
        boot_pending_q <= 1'b0;
        core_run <= 1'b1; // RL4
        fetch_restart <= 1'b1; // RL2
      end
    end
  end

  // ----------------------------------------
  // program fetch
  // ----------------------------------------
  logic fetch_go;
  logic [23:0] fetch_masked;
  logic fetch_in_sram;
  logic [2:0] fetch_len;
  assign fetch_go = fetch_req && core_run && !fetch_busy;
  assign fetch_masked = fetch_addr & space_mask; // RL1
  assign fetch_in_sram = (fetch_masked <= `MXC_PROG_SRAM_TOP); // RL3
  assign fetch_len = fetch_in_sram ? 3'h0 : program_wait_field_q; // RL5 RL8

  always_ff @(posedge ref_clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      prog_addr <= `MXC_RESTART_ADDR;
      prog_sram_sel <= 1'b1;
    end
    else if (fetch_go)
    begin
      prog_addr <= fetch_masked;
      prog_sram_sel <= fetch_in_sram; // RL3
    end
  end

  mxc_wait_timer u_fetch_timer (
    .ref_clk(ref_clk),
    .rst_b(rst_sync_q),
    .start(fetch_go),
    .len(fetch_len),
    .active_q(fetch_busy),
    .done_q(fetch_done)
  );

  // ----------------------------------------
  // external moves
  // ----------------------------------------
  logic xm_go;
  logic [23:0] xm_raw;
  logic [23:0] xm_next;
  logic xm_prog;
  logic [7:0] ptr_top;
  logic [2:0] xm_len;
  assign xm_go = xm_req.valid && core_run && !xm_strobe;
  assign xm_prog = xm_req.wr && power_config_register_q[`MXC_PC_PWE]; // RL15
  assign ptr_top = ptr_regs.ptr_sel ? ptr_regs.pointer_extended_byte1 : ptr_regs.pointer_extended_byte0; // RL17
  assign xm_raw = xm_req.use_ptr ?
    {ptr_top, ptr_regs.pointer_high_byte, ptr_regs.pointer_low_byte} :
    {ptr_regs.indirect_upper_address, ptr_regs.port_two_latch, xm_req.reg_low}; // RL16
  // narrow mode has only 64 KB of code, so the top byte goes to zero there
  assign xm_next = xm_prog ? (xm_raw & space_mask) : (xm_raw & `MXC_WIDE_MASK); // RL16 RL22
  assign xm_len = xm_prog ? program_wait_field_q : clock_control_register_q[2:0]; // RL6 RL23 RL25

  always_ff @(posedge ref_clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      xm_addr <= 24'h00_0000;
      xm_wdata <= 8'h00;
      xm_wr <= 1'b0;
      xm_to_prog <= 1'b0;
      xm_onchip <= 1'b0;
    end
    else if (xm_go)
    begin
      xm_addr <= xm_next;
      xm_wdata <= xm_req.wdata;
      xm_wr <= xm_req.wr;
      xm_to_prog <= xm_prog; // RL15
      xm_onchip <= !xm_prog && (xm_next <= `MXC_DATA_SRAM_TOP); // RL22
    end
  end

  mxc_wait_timer u_xm_timer (
    .ref_clk(ref_clk),
    .rst_b(rst_sync_q),
    .start(xm_go),
    .len(xm_len),
    .active_q(xm_strobe),
    .done_q(xm_done)
  );

  // ----------------------------------------
  // timer prescale
  // ----------------------------------------
  logic [3:0] div_q;
  always_ff @(posedge ref_clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      div_q <= 4'h0;
    else if (div_q == `MXC_DIV_SLOW)
      div_q <= 4'h0;
    else
      div_q <= div_q + 4'h1;
  end

  logic tick_fast;
  logic tick_slow;
  assign tick_fast = (div_q[1:0] == 2'h3);
  assign tick_slow = (div_q == `MXC_DIV_SLOW);

  always_ff @(posedge ref_clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      timer_zero_tick <= 1'b0;
      timer_one_tick <= 1'b0;
    end
    else
    begin
      timer_zero_tick <= clock_control_register_q[`MXC_CK_T0] ? tick_fast : tick_slow; // RL24
      timer_one_tick <= clock_control_register_q[`MXC_CK_T1] ? tick_fast : tick_slow; // RL24
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [3:0] fetch_age_q;
  logic [2:0] fetch_len_q;
  always_ff @(posedge ref_clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      fetch_age_q <= 4'h0;
      fetch_len_q <= 3'h0;
    end
    else if (fetch_go)
    begin
      fetch_age_q <= 4'h0;
      fetch_len_q <= fetch_len;
    end
    else if (fetch_busy)
      fetch_age_q <= fetch_age_q + 4'h1;
  end

  AST_TA_LOCK: assert property (@(posedge ref_clk) disable iff (!rst_sync_q) // RL9
    (wr_mode && !mode_unlocked && !software_reboot_bit) |=> $stable(address_mode_register_q))
    else $error("mode register changed without unlock");
  AST_TA_OPEN: assert property (@(posedge ref_clk) disable iff (!rst_sync_q) // RL10
    (wr_ta && sfr_wdata == `MXC_TA_KEY_FIRST) ##1 (!sfr_wr && !other_instr) [*7]
    ##1 (wr_ta && sfr_wdata == `MXC_TA_KEY_SECOND) |=> mode_unlocked)
    else $error("unlock lost during idle cycles");
  AST_MODE_READ: assert property (@(posedge ref_clk) disable iff (!rst_sync_q) // RL11
    (sfr_rd && sfr_addr == `MXC_ADDR_ADDR_MODE) |=> sfr_rdata == {6'h00, $past(address_mode_register_q)})
    else $error("mode register readback wrong");
  AST_SRAM_FETCH: assert property (@(posedge ref_clk) disable iff (!rst_sync_q) // RL5
    (fetch_go && fetch_in_sram) |=> fetch_done ##1 !fetch_busy)
    else $error("program SRAM fetch not single clock");
  AST_PROG_LEN: assert property (@(posedge ref_clk) disable iff (!rst_sync_q) // RL8
    fetch_done |-> fetch_age_q == {1'b0, fetch_len_q})
    else $error("program access length wrong");
  AST_NARROW: assert property (@(posedge ref_clk) disable iff (!rst_sync_q) // RL1
    ($past(fetch_go) && !$past(wide)) |-> prog_addr[23:16] == 8'h00)
    else $error("narrow fetch address exceeds 64 KB");
  AST_BOOT_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_sync_q) // RL4
    $rose(core_run) |-> $past(boot_copy_done) && fetch_restart)
    else $error("core released without boot copy");
  AST_SWITCHBACK: assert property (@(posedge ref_clk) disable iff (!rst_sync_q) // RL19
    (wake_event && power_config_register_q[`MXC_PC_SWB] && !wr_power_config_register) ##1 1'b1 |=> !power_manage_mode)
    else $error("switchback left power management set");
  AST_PROG_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_sync_q) // RL15
    (xm_go && xm_req.wr && power_config_register_q[`MXC_PC_PWE]) |=> xm_to_prog && !xm_onchip)
    else $error("program write not routed to program memory");
  AST_SLOW_TICK: assert property (@(posedge ref_clk) disable iff (!rst_sync_q) // RL24
    (timer_one_tick && !clock_control_register_q[`MXC_CK_T1] && !wr_clock_and_data_wait_control) ##1 !wr_clock_and_data_wait_control [*2] |=> !timer_one_tick [*4])
    else $error("slow timer prescale too fast");
endmodule
`default_nettype wire

/* rtl/mxc_map.svh */
// register offsets, field positions, reset values and limits for the memory-access control block
`ifndef MXC_MAP_SVH
`define MXC_MAP_SVH
`define MXC_ADDR_POWER_CFG 8'h87
`define MXC_ADDR_CLK_CTRL 8'h8e
`define MXC_ADDR_PROG_WAIT 8'h92
`define MXC_ADDR_ADDR_MODE 8'h9d
`define MXC_ADDR_TIMED_ACCESS 8'hc7
`define MXC_RST_POWER_CFG 8'h00
`define MXC_RST_CLK_CTRL 8'h07
`define MXC_RST_PROG_WAIT 3'h7
`define MXC_RST_ADDR_MODE 2'h0
`define MXC_TA_KEY_FIRST 8'haa
`define MXC_TA_KEY_SECOND 8'h55
`define MXC_PC_PMM 0
`define MXC_PC_STOP 1
`define MXC_PC_SWB 2
`define MXC_PC_RSM 3
`define MXC_PC_PWE 4
`define MXC_PC_SER2X 6
`define MXC_PC_SER1X 7
`define MXC_CK_T0 3
`define MXC_CK_T1 4
`define MXC_AM_BIT 1
`define MXC_NARROW_MASK 24'h00_ffff
`define MXC_WIDE_MASK 24'h1f_ffff
`define MXC_PROG_SRAM_TOP 24'h00_3fff
`define MXC_DATA_SRAM_TOP 24'h00_7fff
`define MXC_RESTART_ADDR 24'h00_0000
`define MXC_DIV_SLOW 4'hb
`endif

/* rtl/mxc_pkg.sv */
// types shared by the memory-access control block
package mxc_pkg;
  typedef enum logic [1:0] {TA_LOCKED, TA_GOT_FIRST, TA_OPEN} mxc_ta_state_t;
  // one external move request from the core
  typedef struct packed {
    logic valid;
    logic wr;
    logic use_ptr;
    logic [7:0] reg_low;
    logic [7:0] wdata;
  } mxc_xm_req_t;
  // the address registers of the core used by external moves
  typedef struct packed {
    logic ptr_sel;
    logic [7:0] pointer_extended_byte0;
    logic [7:0] pointer_extended_byte1;
    logic [7:0] pointer_high_byte;
    logic [7:0] pointer_low_byte;
    logic [7:0] indirect_upper_address;
    logic [7:0] port_two_latch;
  } mxc_ptr_regs_t;
endpackage

/* rtl/mxc_wait_timer.sv */
// access-length timer: strobe for len+1 clocks, done on the last one
`timescale 1ns/1ps
`default_nettype none
module mxc_wait_timer (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [2:0] len,
  output logic active_q,
  output logic done_q
);
  import mxc_pkg::*;
  logic [2:0] cnt_q;

  // length is latched at start, so a later change never disturbs a running access
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_q <= 3'h0;
      active_q <= 1'b0;
      done_q <= 1'b0;
    end
    else if (start && !active_q)
    begin
      cnt_q <= len;
      active_q <= 1'b1;
      done_q <= (len == 3'h0);
    end
    else if (active_q)
    begin
      if (cnt_q == 3'h0)
      begin
        active_q <= 1'b0;
        done_q <= 1'b0;
      end
      else
      begin
        cnt_q <= cnt_q - 3'h1;
        done_q <= (cnt_q == 3'h1);
      end
    end
  end
endmodule
`default_nettype wire

/* dv/mxc_far_model.sv */
// boot-loader and program-memory stand-in on the far side of the memory-access block
`timescale 1ns/1ps
`default_nettype none
module mxc_far_model #(
  parameter int COPY_CYCLES = 20
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic boot_copy_start,
  output logic boot_copy_done,
  input wire logic xm_done,
  input wire logic xm_wr,
  input wire logic [23:0] xm_addr,
  input wire logic [7:0] xm_wdata,
  output logic [31:0] last_write
);
  int cnt;
  // ------------------------------------------------------------
  // shadow copy: slow on purpose, the core must wait for the pulse
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt <= 0;
      boot_copy_done <= 1'b0;
    end
    else
    begin
      boot_copy_done <= (cnt == 1);
      if (boot_copy_start)
        cnt <= COPY_CYCLES;
      else if (cnt > 0)
        cnt <= cnt - 1;
    end
  end
  // last byte stored by a finished write
  always_ff @(posedge ref_clk)
  begin
    if (xm_done && xm_wr)
      last_write <= {xm_addr, xm_wdata};
  end
endmodule
`default_nettype wire

/* dv/tb_top.sv */
// self-checking bench for the memory-access control block
`timescale 1ns/1ps
`default_nettype none
`include "mxc_map.svh"
module tb_top;
  import mxc_pkg::*;
  logic ref_clk, rst_b, sfr_wr, sfr_rd, other_instr, software_reboot_bit, wake_event, fetch_req;
  logic boot_copy_done, boot_copy_start, core_run, fetch_restart, prog_sram_sel, fetch_busy, fetch_done;
  logic xm_wr, xm_to_prog, xm_onchip, xm_strobe, xm_done, addr_width_select, power_manage_mode, stop_mode;
  logic regulator_standby, serial_first_double_rate, serial_second_double_rate, timer_zero_tick, timer_one_tick;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, xm_wdata;
  logic [23:0] fetch_addr, prog_addr, xm_addr;
  logic [31:0] last_write;
  logic restart_seen;
  mxc_xm_req_t xm_req;
  mxc_ptr_regs_t ptr_regs;
  int n_mismatch = 0;
  int cmp_count = 0;
  int n, g;
  mxc_mem_ctrl dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .other_instr(other_instr),
    .software_reboot_bit(software_reboot_bit), .boot_copy_done(boot_copy_done),
    .boot_copy_start(boot_copy_start), .core_run(core_run), .fetch_restart(fetch_restart),
    .fetch_req(fetch_req), .fetch_addr(fetch_addr), .prog_addr(prog_addr), .prog_sram_sel(prog_sram_sel),
    .fetch_busy(fetch_busy), .fetch_done(fetch_done), .xm_req(xm_req), .ptr_regs(ptr_regs),
    .xm_addr(xm_addr), .xm_wdata(xm_wdata), .xm_wr(xm_wr), .xm_to_prog(xm_to_prog), .xm_onchip(xm_onchip),
    .xm_strobe(xm_strobe), .xm_done(xm_done), .wake_event(wake_event), .addr_width_select(addr_width_select),
    .power_manage_mode(power_manage_mode), .stop_mode(stop_mode), .regulator_standby(regulator_standby),
    .serial_first_double_rate(serial_first_double_rate), .serial_second_double_rate(serial_second_double_rate),
    .timer_zero_tick(timer_zero_tick), .timer_one_tick(timer_one_tick));
  mxc_far_model far_u (.ref_clk(ref_clk), .rst_b(rst_b), .boot_copy_start(boot_copy_start),
    .boot_copy_done(boot_copy_done), .xm_done(xm_done), .xm_wr(xm_wr), .xm_addr(xm_addr),
    .xm_wdata(xm_wdata), .last_write(last_write));
  // ------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge ref_clk);
    sfr_wr = 1'b0;
  endtask
  task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(negedge ref_clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge ref_clk);
    sfr_rd = 1'b0;
    chk(what, sfr_rdata, exp);
  endtask
  task automatic unlock;
    wr(`MXC_ADDR_TIMED_ACCESS, `MXC_TA_KEY_FIRST);
    wr(`MXC_ADDR_TIMED_ACCESS, `MXC_TA_KEY_SECOND);
  endtask
  task automatic pulse(input int which);
    @(negedge ref_clk);
    case (which)
      0: other_instr = 1'b1;
      1: wake_event = 1'b1;
      default: software_reboot_bit = 1'b1;
    endcase
    @(negedge ref_clk);
    other_instr = 1'b0;
    wake_event = 1'b0;
    software_reboot_bit = 1'b0;
  endtask
  // counts clocks from the accepting edge to the done pulse
  task automatic fetch(input logic [23:0] a, output int k);
    @(negedge ref_clk);
    while (fetch_busy !== 1'b0) @(negedge ref_clk);
    fetch_addr = a;
    fetch_req = 1'b1;
    @(negedge ref_clk);
    fetch_req = 1'b0;
    k = 1;
    while (fetch_done !== 1'b1 && k < 20)
    begin
      @(negedge ref_clk);
      k++;
    end
  endtask
  task automatic move(input logic w, input logic p, input logic [7:0] lo, input logic [7:0] d, output int k);
    @(negedge ref_clk);
    while (xm_strobe !== 1'b0) @(negedge ref_clk);
    xm_req = '{1'b1, w, p, lo, d};
    @(negedge ref_clk);
    xm_req.valid = 1'b0;
    k = 1;
    while (xm_done !== 1'b1 && k < 20)
    begin
      @(negedge ref_clk);
      k++;
    end
  endtask
  task automatic wait_run;
    int k;
    k = 0;
    restart_seen = 1'b0;
    while (core_run !== 1'b1 && k < 200)
    begin
      @(negedge ref_clk);
      restart_seen |= (fetch_restart === 1'b1);
      k++;
    end
    repeat (2)
    begin
      @(negedge ref_clk);
      restart_seen |= (fetch_restart === 1'b1);
    end
  endtask
  task automatic gap(input bit one, output int k);
    int j;
    j = 0;
    @(negedge ref_clk);
    while ((one ? timer_one_tick : timer_zero_tick) !== 1'b1 && j < 30)
    begin
      @(negedge ref_clk);
      j++;
    end
    k = 0;
    do
    begin
      @(negedge ref_clk);
      k++;
    end
    while ((one ? timer_one_tick : timer_zero_tick) !== 1'b1 && k < 30);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ------------------------------------------------------------
  // clock, watchdog, sequence
  // ------------------------------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // the whole sequence needs about 450 clocks
  initial
  begin
    #100us;
    n_mismatch++;
    tally_and_finish();
  end
  initial
  begin
    {rst_b, sfr_wr, sfr_rd, other_instr, software_reboot_bit, wake_event, fetch_req} = '0;
    {sfr_addr, sfr_wdata, fetch_addr} = '0;
    xm_req = '0;
    ptr_regs = '0;
    repeat (8) @(negedge ref_clk);
    chk("copy_start_in_reset", boot_copy_start, 1);
    rst_b = 1'b1;
    fetch_req = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk("busy_while_held", fetch_busy, 0);
    fetch_req = 1'b0;
    wait_run();
    chk("restart_after_copy", restart_seen, 1);
    rdc("power_reset", `MXC_ADDR_POWER_CFG, 8'h00);
    rdc("clock_reset", `MXC_ADDR_CLK_CTRL, 8'h07);
    rdc("wait_reset", `MXC_ADDR_PROG_WAIT, 8'h07);
    rdc("mode_reset", `MXC_ADDR_ADDR_MODE, 8'h00);
    rdc("unmapped", 8'h80, 8'h00);
    wr(`MXC_ADDR_ADDR_MODE, 8'h02);
    rdc("mode_locked", `MXC_ADDR_ADDR_MODE, 8'h00);
    unlock();
    wr(`MXC_ADDR_ADDR_MODE, 8'hfe);
    rdc("mode_wide", `MXC_ADDR_ADDR_MODE, 8'h02);
    chk("width_wide", addr_width_select, 1);
    fetch(24'h3f_5678, n);
    chk("wide_mask", prog_addr, 24'h1f_5678);
    wr(`MXC_ADDR_TIMED_ACCESS, `MXC_TA_KEY_FIRST);
    repeat (6) @(negedge ref_clk);
    wr(`MXC_ADDR_TIMED_ACCESS, `MXC_TA_KEY_SECOND);
    repeat (6) @(negedge ref_clk);
    wr(`MXC_ADDR_ADDR_MODE, 8'h00);
    rdc("mode_gaps", `MXC_ADDR_ADDR_MODE, 8'h00);
    chk("width_narrow", addr_width_select, 0);
    fetch(24'h12_5678, n);
    chk("narrow_mask", prog_addr, 24'h00_5678);
    unlock();
    pulse(0);
    wr(`MXC_ADDR_ADDR_MODE, 8'h02);
    rdc("relock_instr", `MXC_ADDR_ADDR_MODE, 8'h00);
    unlock();
    wr(`MXC_ADDR_POWER_CFG, 8'h00);
    wr(`MXC_ADDR_ADDR_MODE, 8'h02);
    rdc("relock_write", `MXC_ADDR_ADDR_MODE, 8'h00);
    wr(`MXC_ADDR_PROG_WAIT, 8'hf9);
    rdc("wait_field", `MXC_ADDR_PROG_WAIT, 8'h01);
    for (int w = 0; w < 8; w++)
    begin
      wr(`MXC_ADDR_PROG_WAIT, w[7:0]);
      fetch(24'h00_4000, n);
      chk("fetch_len", n, w + 1);
      chk("flash_sel", prog_sram_sel, 0);
    end
    fetch(24'h00_3fff, n);
    chk("sram_len", n, 1);
    chk("sram_sel", prog_sram_sel, 1);
    ptr_regs = '{1'b1, 8'h00, 8'h05, 8'h80, 8'h01, 8'h07, 8'h9a};
    for (int m = 0; m < 8; m++)
    begin
      wr(`MXC_ADDR_CLK_CTRL, m[7:0]);
      move(1'b0, 1'b1, 8'h00, 8'h00, n);
      chk("data_len", n, m + 1);
    end
    chk("ptr_addr", xm_addr, 24'h05_8001);
    chk("ext_data", {xm_onchip, xm_to_prog}, 0);
    ptr_regs = '{1'b0, 8'h00, 8'h05, 8'h7f, 8'hff, 8'h07, 8'h9a};
    fork
      move(1'b0, 1'b1, 8'h00, 8'h00, n);
      #30 wr(`MXC_ADDR_CLK_CTRL, 8'h00);
    join
    chk("len_latched", n, 8);
    chk("onchip_top", {xm_addr, xm_onchip}, {24'h00_7fff, 1'b1});
    move(1'b0, 1'b1, 8'h00, 8'h00, n);
    chk("len_next", n, 1);
    wr(`MXC_ADDR_POWER_CFG, 8'h10);
    wr(`MXC_ADDR_PROG_WAIT, 8'h02);
    move(1'b1, 1'b0, 8'hbc, 8'h5a, n);
    chk("prog_wr_len", n, 3);
    chk("prog_wr_narrow", {xm_to_prog, xm_addr}, {1'b1, 24'h00_9abc});
    unlock();
    chk("prog_wr_stored", last_write, 32'h009a_bc5a);
    wr(`MXC_ADDR_ADDR_MODE, 8'h02);
    move(1'b1, 1'b0, 8'hbc, 8'h5a, n);
    chk("prog_wr_wide", xm_addr, 24'h07_9abc);
    wr(`MXC_ADDR_POWER_CFG, 8'h00);
    move(1'b1, 1'b0, 8'hbc, 8'h5a, n);
    chk("data_wr", {xm_to_prog, n[3:0]}, 5'h01);
    wr(`MXC_ADDR_POWER_CFG, 8'hda);
    rdc("power_rb", `MXC_ADDR_POWER_CFG, 8'hda);
    chk("power_outs", {serial_first_double_rate, serial_second_double_rate, regulator_standby, stop_mode,
      power_manage_mode}, 5'b11110);
    wr(`MXC_ADDR_POWER_CFG, 8'h05);
    pulse(1);
    rdc("switchback", `MXC_ADDR_POWER_CFG, 8'h04);
    chk("pmm_cleared", power_manage_mode, 0);
    wr(`MXC_ADDR_POWER_CFG, 8'h01);
    pulse(1);
    rdc("no_switchback", `MXC_ADDR_POWER_CFG, 8'h01);
    chk("pmm_kept", power_manage_mode, 1);
    wr(`MXC_ADDR_POWER_CFG, 8'h00);
    for (int c = 0; c < 4; c++)
    begin
      wr(`MXC_ADDR_CLK_CTRL, 8'(c << 3));
      gap(1'b0, g);
      chk("timer0_gap", g, c[0] ? 4 : 12);
      gap(1'b1, g);
      chk("timer1_gap", g, c[1] ? 4 : 12);
    end
    pulse(2);
    chk("core_held", core_run, 0);
    wait_run();
    chk("reboot_restart", {restart_seen, addr_width_select}, 2'b10);
    rdc("reboot_mode", `MXC_ADDR_ADDR_MODE, 8'h00);
    tally_and_finish();
  end
endmodule
`default_nettype wire
